// ===== hirq_params.svh
`ifndef HIRQ_PARAMS_SVH
`define HIRQ_PARAMS_SVH

// ==========================================================================
// Register map
`define HIRQ_CFG_OFFSET     8'h54
`define HIRQ_STS_OFFSET     8'h58
`define HIRQ_CFG_RESET      32'h00000000
`define HIRQ_STS_RESET      32'h00000000

// ==========================================================================
// Pin configuration fields
`define HIRQ_INTERVAL_MSB   31
`define HIRQ_INTERVAL_LSB   24
`define HIRQ_RESTART_BIT    14
`define HIRQ_ACTIVE_BIT     13
`define HIRQ_MASTER_BIT     12
`define HIRQ_ENABLE_BIT     8
`define HIRQ_POL_BIT        4
`define HIRQ_TYPE_BIT       0

// ==========================================================================
// Flag status fields
`define HIRQ_SW_BIT         31
`define HIRQ_TXH_BIT        25
`define HIRQ_RXH_BIT        24
`define HIRQ_DROP_BIT       23
`define HIRQ_PME_BIT        17
`define HIRQ_CFG_RSVD       32'h00FFCEEE
`define HIRQ_STS_RSVD       32'h7C7DFFFF
`define HIRQ_DROP_BEFORE    32'h7FFFFFFF
`define HIRQ_DROP_AFTER     32'h80000000

// ==========================================================================
// Timing
`define HIRQ_UNIT_NS        10000
`define HIRQ_CLK_NS         8
`define HIRQ_UNIT_CYCLES    ((`HIRQ_UNIT_NS + `HIRQ_CLK_NS - 1) / `HIRQ_CLK_NS)

`endif

// ===== hirq_pkg.sv
package hirq_pkg;

  typedef enum logic [0:0] {
    HIRQ_IDLE = 1'b0,
    HIRQ_HOLD = 1'b1
  } hirq_hold_e;

  typedef struct packed {
    logic [7:0]  interval;
    logic        enable;
    logic        polarity;
    logic        push_pull;
    hirq_hold_e  hold;
    logic [7:0]  count;
    logic        restart_tick;
    logic        sw_flag;
    logic        txh_flag;
    logic        rxh_flag;
    logic        drop_flag;
    logic        pme_flag;
    logic        arm_q;
    logic        tx_done_q;
    logic        rx_stop_q;
    logic [31:0] drop_q;
    logic        master;
    logic        asserted;
    logic        pin;
    logic        oe;
    logic [31:0] rdata;
    logic        rvalid;
  } hirq_state_s;

endpackage : hirq_pkg

// ===== hirq_tick.sv
`timescale 1ns/1ps
`include "hirq_params.svh"

module hirq_tick #(
  parameter int DIV = `HIRQ_UNIT_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic restart_in,
  output logic      tick_out
);

  localparam int W = $clog2(DIV);

  if (DIV < 2) begin : g_bad_div
    $error("hirq_tick: DIV must be at least 2");
  end

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } hirq_tick_s;

  hirq_tick_s s;
  hirq_tick_s next_s;

  localparam logic [W-1:0] LAST = W'(DIV - 1);

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    // A restart realigns the time base so a fresh interval gets full units
    if (restart_in) begin
      next_s.count = '0;
    end else if (s.count == LAST) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + W'(1);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  chk_tick_spacing: assert property (
    @(posedge clock_in) disable iff (rst_in)
    s.tick |-> (($past(s.count) == LAST) && !$past(restart_in))
  ) else $error("time base tick out of step");

  assign tick_out = s.tick;

endmodule : hirq_tick

// ===== hirq_top.sv
`timescale 1ns/1ps
`include "hirq_params.svh"

module hirq_top
  import hirq_pkg::*;
#(
  parameter int TICK_DIV = `HIRQ_UNIT_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  output logic             reg_rvalid_out,
  input  wire logic [31:0] source_mask_in,
  input  wire logic        other_request_in,
  input  wire logic        tx_halt_request_in,
  input  wire logic        tx_stopped_in,
  input  wire logic        rx_stopped_in,
  input  wire logic [31:0] drop_count_in,
  input  wire logic        power_event_in,
  input  wire logic        power_event_output_in,
  output logic             irq_pin_out,
  output logic             irq_oe_out,
  output logic             irq_request_out
);

  if (TICK_DIV < 2) begin : g_bad_div
    $error("hirq_top: TICK_DIV must be at least 2");
  end

  // ========================================================================
  // State and decode
  hirq_state_s s;
  hirq_state_s next_s;

  logic tick;
  logic wr_cfg;
  logic wr_sts;
  logic clr_sw;
  logic clr_txh;
  logic clr_rxh;
  logic clr_drop;
  logic clr_pme;
  logic set_sw;
  logic set_txh;
  logic set_rxh;
  logic set_drop;
  logic tx_done;
  logic pme_req;
  logic gen_req;
  logic assert_now;
  logic hold_end;
  logic unit_tick;

  assign wr_cfg   = reg_wr_in && (reg_addr_in == `HIRQ_CFG_OFFSET);
  assign wr_sts   = reg_wr_in && (reg_addr_in == `HIRQ_STS_OFFSET);
  // Write one to clear; zeros written leave the flag alone
  assign clr_sw   = wr_sts && reg_wdata_in[`HIRQ_SW_BIT];
  assign clr_txh  = wr_sts && reg_wdata_in[`HIRQ_TXH_BIT];
  assign clr_rxh  = wr_sts && reg_wdata_in[`HIRQ_RXH_BIT];
  assign clr_drop = wr_sts && reg_wdata_in[`HIRQ_DROP_BIT];
  // The power pin level is deliberately not looked at here
  assign clr_pme  = wr_sts && reg_wdata_in[`HIRQ_PME_BIT];

  assign tx_done  = tx_halt_request_in && tx_stopped_in;
  assign set_sw   = source_mask_in[`HIRQ_SW_BIT] && !s.arm_q;
  assign set_txh  = tx_done && !s.tx_done_q;
  assign set_rxh  = rx_stopped_in && !s.rx_stop_q;
  assign set_drop = (s.drop_q == `HIRQ_DROP_BEFORE)
                 && (drop_count_in == `HIRQ_DROP_AFTER);

  // Masking happens only on the way to the request line
  assign gen_req = (s.sw_flag   && source_mask_in[`HIRQ_SW_BIT])
                || (s.txh_flag  && source_mask_in[`HIRQ_TXH_BIT])
                || (s.rxh_flag  && source_mask_in[`HIRQ_RXH_BIT])
                || (s.drop_flag && source_mask_in[`HIRQ_DROP_BIT])
                || other_request_in;
  assign pme_req = s.pme_flag && source_mask_in[`HIRQ_PME_BIT];

  // Power event requests skip the holdoff gate
  assign assert_now = s.enable
                   && (pme_req || (gen_req && (s.hold == HIRQ_IDLE)));

  // A tick already in flight when the time base restarts belongs to the old unit
  assign unit_tick = tick && !s.restart_tick;

  // Compare against the live field so a lowered value ends early
  assign hold_end = unit_tick
                 && (({1'b0, s.count} + 9'h001) >= {1'b0, s.interval});

  // ========================================================================
  // Time base
  hirq_tick #(
    .DIV        (TICK_DIV)
  ) u_tick (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .restart_in (s.restart_tick),
    .tick_out   (tick)
  );

  // ========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.restart_tick = 1'b0;

    // Reserved bits are never stored
    if (wr_cfg) begin
      next_s.interval  = reg_wdata_in[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB];
      next_s.enable    = reg_wdata_in[`HIRQ_ENABLE_BIT];
      next_s.polarity  = reg_wdata_in[`HIRQ_POL_BIT];
      next_s.push_pull = reg_wdata_in[`HIRQ_TYPE_BIT];
    end

    // Set wins over a same-cycle clear; only the software flag uses a mask bit here, whose rising edge sets it
    next_s.sw_flag   = (s.sw_flag   && !clr_sw)   || set_sw;
    next_s.txh_flag  = (s.txh_flag  && !clr_txh)  || set_txh;
    next_s.rxh_flag  = (s.rxh_flag  && !clr_rxh)  || set_rxh;
    next_s.drop_flag = (s.drop_flag && !clr_drop) || set_drop;
    next_s.pme_flag  = (s.pme_flag  && !clr_pme)  || power_event_in;

    next_s.arm_q     = source_mask_in[`HIRQ_SW_BIT];
    next_s.tx_done_q = tx_done;
    next_s.rx_stop_q = rx_stopped_in;
    next_s.drop_q    = drop_count_in;

    next_s.master    = gen_req || pme_req;

    // Holdoff sequencing
    if (next_s.interval == 8'h00) begin
      next_s.hold  = HIRQ_IDLE;
      next_s.count = 8'h00;
    end else if (wr_cfg && reg_wdata_in[`HIRQ_RESTART_BIT]) begin
      next_s.hold  = HIRQ_HOLD;
      next_s.count = 8'h00;
      next_s.restart_tick = 1'b1;
    end else if (s.asserted && !assert_now) begin
      next_s.hold  = HIRQ_HOLD;
      next_s.count = 8'h00;
      next_s.restart_tick = 1'b1;
    end else if ((s.hold == HIRQ_HOLD) && hold_end) begin
      next_s.hold  = HIRQ_IDLE;
      next_s.count = 8'h00;
    end else if ((s.hold == HIRQ_HOLD) && unit_tick) begin
      next_s.count = s.count + 8'h01;
    end

    // Pin driver; open-drain only ever pulls low
    next_s.asserted = assert_now;
    if (next_s.push_pull) begin
      next_s.pin = next_s.polarity ? assert_now : !assert_now;
      next_s.oe  = 1'b1;
    end else begin
      next_s.pin = 1'b0;
      next_s.oe  = assert_now;
    end

    // Register reads answer one cycle later; unmapped reads return zero
    if (reg_rd_in) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = 32'h00000000;
      if (reg_addr_in == `HIRQ_CFG_OFFSET) begin
        next_s.rdata[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB] = s.interval;
        next_s.rdata[`HIRQ_ACTIVE_BIT] = (s.hold == HIRQ_HOLD);
        next_s.rdata[`HIRQ_MASTER_BIT] = s.master;
        next_s.rdata[`HIRQ_ENABLE_BIT] = s.enable;
        next_s.rdata[`HIRQ_POL_BIT]    = s.polarity;
        next_s.rdata[`HIRQ_TYPE_BIT]   = s.push_pull;
      end else if (reg_addr_in == `HIRQ_STS_OFFSET) begin
        next_s.rdata[`HIRQ_SW_BIT]   = s.sw_flag;
        next_s.rdata[`HIRQ_TXH_BIT]  = s.txh_flag;
        next_s.rdata[`HIRQ_RXH_BIT]  = s.rxh_flag;
        next_s.rdata[`HIRQ_DROP_BIT] = s.drop_flag;
        next_s.rdata[`HIRQ_PME_BIT]  = s.pme_flag;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata_out   = s.rdata;
  assign reg_rvalid_out  = s.rvalid;
  assign irq_pin_out     = s.pin;
  assign irq_oe_out      = s.oe;
  assign irq_request_out = s.master;

  // ========================================================================
  // Checks
  logic pin_idle;
  assign pin_idle = s.push_pull ? (s.pin == !s.polarity) : !s.oe;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  chk_interval_unit: assert property (
    ((s.hold == HIRQ_HOLD) && (next_s.hold == HIRQ_IDLE))
    |-> (unit_tick || (next_s.interval == 8'h00))
  ) else $error("holdoff ended off a unit boundary");

  chk_zero_disables: assert property (
    (s.interval == 8'h00) |-> (s.hold == HIRQ_IDLE) && (s.count == 8'h00)
  ) else $error("holdoff running with zero interval");

  chk_pme_bypass: assert property (
    (s.enable && pme_req && (s.hold == HIRQ_HOLD)) |=> s.asserted
  ) else $error("power event delayed by holdoff");

  chk_restart_fresh: assert property (
    (wr_cfg && reg_wdata_in[`HIRQ_RESTART_BIT]
     && (reg_wdata_in[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB] != 8'h00))
    |=> (s.hold == HIRQ_HOLD) && (s.count == 8'h00) && s.restart_tick
  ) else $error("restart did not begin a fresh interval");

  chk_hold_blocks: assert property (
    ((s.hold == HIRQ_HOLD) && !pme_req) |=> !s.asserted
  ) else $error("pin asserted during holdoff");

  chk_disabled_idle: assert property (
    !s.enable |=> pin_idle
  ) else $error("pin active while output disabled");

  chk_open_drain_low: assert property (
    !s.push_pull |-> (s.pin == 1'b0)
  ) else $error("open-drain pin driven high");

  chk_polarity_pin: assert property (
    (s.push_pull && s.oe) |-> (s.pin == (s.polarity ~^ s.asserted))
  ) else $error("push-pull level disagrees with polarity");

  chk_sw_clear: assert property (
    (clr_sw && !set_sw) |=> !s.sw_flag
  ) else $error("software flag not cleared by write one");

  chk_drop_half: assert property (
    set_drop |=> s.drop_flag
  ) else $error("drop half flag missed");

  chk_hold_start: assert property (
    (s.asserted && !assert_now && (next_s.interval != 8'h00)) |=> (s.hold == HIRQ_HOLD)
  ) else $error("holdoff did not start on deassertion");

  chk_zero_delivers: assert property (
    ((s.interval == 8'h00) && s.enable && other_request_in) |=> s.asserted
  ) else $error("pending request held back with holdoff off");

  chk_new_interval: assert property (
    (wr_cfg && (reg_wdata_in[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB] != 8'h00))
    |=> (s.interval == $past(reg_wdata_in[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB]))
  ) else $error("written interval not taken");

  chk_master_follows: assert property (
    (other_request_in || pme_req) |=> s.master
  ) else $error("master request missed an active source");

  chk_master_quiet: assert property (
    (!other_request_in && !source_mask_in[`HIRQ_SW_BIT] && !source_mask_in[`HIRQ_TXH_BIT]
     && !source_mask_in[`HIRQ_RXH_BIT] && !source_mask_in[`HIRQ_DROP_BIT]
     && !source_mask_in[`HIRQ_PME_BIT]) |=> !s.master
  ) else $error("masked flag reached the request line");

  chk_sw_set: assert property (
    $rose(source_mask_in[`HIRQ_SW_BIT]) |=> s.sw_flag
  ) else $error("software flag missed arm edge");

  chk_tx_set: assert property (
    $rose(tx_halt_request_in && tx_stopped_in) |=> s.txh_flag
  ) else $error("transmit halted flag missed");

  chk_tx_needs_req: assert property (
    (!tx_halt_request_in && !s.txh_flag) |=> !s.txh_flag
  ) else $error("transmit halted flag set without halt request");

  chk_rx_set: assert property (
    $rose(rx_stopped_in) |=> s.rxh_flag
  ) else $error("receive halted flag missed");

  chk_flag_unmasked: assert property (
    (power_event_in && !source_mask_in[`HIRQ_PME_BIT]) |=> s.pme_flag
  ) else $error("masked event not recorded");

  chk_zero_keeps: assert property (
    (wr_sts && !reg_wdata_in[`HIRQ_RXH_BIT] && s.rxh_flag) |=> s.rxh_flag
  ) else $error("flag cleared by a zero write");

  chk_pme_clear: assert property (
    (wr_sts && reg_wdata_in[`HIRQ_PME_BIT] && !power_event_in) |=> !s.pme_flag
  ) else $error("power event flag not cleared");

  chk_cfg_reserved: assert property (
    (reg_rd_in && (reg_addr_in == `HIRQ_CFG_OFFSET))
    |=> ((reg_rdata_out & `HIRQ_CFG_RSVD) == 32'h00000000)
  ) else $error("reserved config bit read as one");

  chk_sts_reserved: assert property (
    (reg_rd_in && (reg_addr_in == `HIRQ_STS_OFFSET))
    |=> ((reg_rdata_out & `HIRQ_STS_RSVD) == 32'h00000000)
  ) else $error("reserved status bit read as one");

  cov_holdoff_end: cover property (
    (s.hold == HIRQ_HOLD) ##1 (s.hold == HIRQ_IDLE)
  );

  cov_pme_in_hold: cover property (
    (s.hold == HIRQ_HOLD) && pme_req && s.enable
  );

  cov_restart: cover property (
    wr_cfg && reg_wdata_in[`HIRQ_RESTART_BIT] && (s.hold == HIRQ_HOLD)
  );

  cov_drop_half: cover property (
    set_drop
  );

  cov_zero_release: cover property (
    (s.hold == HIRQ_HOLD) && wr_cfg && (reg_wdata_in[`HIRQ_INTERVAL_MSB:`HIRQ_INTERVAL_LSB] == 8'h00)
  );

  // The power pin only matters to the far side; keep it visibly consumed
  logic unused_pin;
  assign unused_pin = power_event_output_in;

endmodule : hirq_top

// ===== hirq_host_model.sv
`timescale 1ns/1ps

// ==========================================================================
// Host CPU: register bus master and interrupt input with a board pull-up
module hirq_host_model (
  input  wire logic        clock_in,
  input  wire logic        irq_pin_in,
  input  wire logic        irq_oe_in,
  input  wire logic [31:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  output logic      [7:0]  reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic      [31:0] reg_wdata_out,
  output logic             irq_level_out
);
  // Released open-drain pin floats up; only a driving party sets the level
  assign irq_level_out = irq_oe_in ? irq_pin_in : 1'b1;

  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 32'h00000000;
  end

  // Acknowledge is a write of ones; zero bits leave flags alone
  task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock_in);
    reg_addr_out  <= addr;
    reg_wdata_out <= data;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    // Idle bus shows inverted values so stale data never looks valid
    reg_addr_out  <= ~addr;
    reg_wdata_out <= ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output bit ok);
    int n;
    ok   = 1'b0;
    data = 32'h00000000;
    @(posedge clock_in);
    reg_addr_out <= addr;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~addr;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clock_in);
      if (reg_rvalid_in === 1'b1) begin
        data = reg_rdata_in;
        ok   = 1'b1;
      end
    end
  endtask : read_reg
endmodule : hirq_host_model

// ===== test_host_irq_output_control.sv
`timescale 1ns/1ps

module test_host_irq_output_control;
  import hirq_pkg::*;

  typedef struct {
    logic [31:0] cfg;
    logic        req;
    logic        level;
    logic        master;
  } hirq_row_s;

  localparam int TDIV = 8;

  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [31:0] source_mask  = 32'h00000000;
  logic        other_req    = 1'b0;
  logic        tx_halt_req  = 1'b0;
  logic        tx_stopped   = 1'b0;
  logic        rx_stopped   = 1'b0;
  logic [31:0] drop_count   = 32'h00000000;
  logic        power_event  = 1'b0;
  logic        pe_output    = 1'b0;
  logic        irq_pin;
  logic        irq_oe;
  logic        irq_request;
  logic        irq_level;
  int          error_cnt    = 0;
  int          total_checks = 0;

  hirq_row_s rows [8] = '{
    '{32'h00000100, 1'b1, 1'b0, 1'b1}, '{32'h00000110, 1'b1, 1'b0, 1'b1},
    '{32'h00000101, 1'b1, 1'b0, 1'b1}, '{32'h00000111, 1'b1, 1'b1, 1'b1},
    '{32'h00000011, 1'b1, 1'b0, 1'b1}, '{32'h00000010, 1'b1, 1'b1, 1'b1},
    '{32'h00000111, 1'b0, 1'b0, 1'b0}, '{32'h00000101, 1'b0, 1'b1, 1'b0}};

  always #4 clock_in = ~clock_in;

  hirq_top #(.TICK_DIV(TDIV)) hirq_top_i (
    .clock_in              (clock_in),
    .rst_in                (rst_in),
    .reg_addr_in           (reg_addr),
    .reg_wr_in             (reg_wr),
    .reg_rd_in             (reg_rd),
    .reg_wdata_in          (reg_wdata),
    .reg_rdata_out         (reg_rdata),
    .reg_rvalid_out        (reg_rvalid),
    .source_mask_in        (source_mask),
    .other_request_in      (other_req),
    .tx_halt_request_in    (tx_halt_req),
    .tx_stopped_in         (tx_stopped),
    .rx_stopped_in         (rx_stopped),
    .drop_count_in         (drop_count),
    .power_event_in        (power_event),
    .power_event_output_in (pe_output),
    .irq_pin_out           (irq_pin),
    .irq_oe_out            (irq_oe),
    .irq_request_out       (irq_request)
  );

  hirq_host_model hirq_host_model_i (
    .clock_in      (clock_in),
    .irq_pin_in    (irq_pin),
    .irq_oe_in     (irq_oe),
    .reg_rdata_in  (reg_rdata),
    .reg_rvalid_in (reg_rvalid),
    .reg_addr_out  (reg_addr),
    .reg_wr_out    (reg_wr),
    .reg_rd_out    (reg_rd),
    .reg_wdata_out (reg_wdata),
    .irq_level_out (irq_level)
  );

  // ==========================================================================
  // Shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Returns on the edge: reads see settled values, drives land on the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cycles

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    hirq_host_model_i.write_reg(addr, data);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] data;
    bit          ok;
    hirq_host_model_i.read_reg(addr, data, ok);
    if (!ok) begin
      check({name, " rvalid"}, 32'h0, 32'h1);
      end_sim();
    end else begin
      check(name, data, exp);
    end
  endtask : rd

  // Cycles until the pin level reads active high; must land in [lo, hi]
  task automatic measure(input string name, input int lo, input int hi);
    int n;
    n = 0;
    while (irq_level !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
    end
    if (n >= 200) begin
      check(name, 32'h0, 32'h1);
      end_sim();
    end else begin
      check(name, 32'(n >= lo && n <= hi), 32'h1);
    end
  endtask : measure

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    cycles(1);
    check("reset level", irq_level, 1'b1);
    check("reset request", irq_request, 1'b0);
    rd("cfg reset", 8'h54, 32'h00000000);
    rd("sts reset", 8'h58, 32'h00000000);
    wr(8'h54, 32'hFFFFBFFF);
    rd("cfg reserved", 8'h54, 32'hFF000111);
    wr(8'h60, 32'hFFFFFFFF);
    rd("unmapped", 8'h60, 32'h00000000);

    foreach (rows[i]) begin
      wr(8'h54, rows[i].cfg);
      @(posedge clock_in);
      other_req <= rows[i].req;
      cycles(4);
      check($sformatf("level row %0d", i), irq_level, rows[i].level);
      check($sformatf("master row %0d", i), irq_request, rows[i].master);
    end

    // Flag sources; mask is clear so flags still record
    @(posedge clock_in);
    tx_stopped  <= 1'b1;
    drop_count  <= 32'h7FFFFFFE;
    cycles(3);
    rd("sts stop only", 8'h58, 32'h00000000);
    @(posedge clock_in);
    tx_halt_req <= 1'b1;
    rx_stopped  <= 1'b1;
    drop_count  <= 32'h7FFFFFFF;
    power_event <= 1'b1;
    @(posedge clock_in);
    drop_count  <= 32'h80000000;
    power_event <= 1'b0;
    source_mask <= 32'h80000000;
    @(posedge clock_in);
    drop_count  <= 32'h80000001;
    cycles(3);
    rd("sts all set", 8'h58, 32'h83820000);
    check("sw request", irq_request, 1'b1);
    wr(8'h58, 32'h80800000);
    rd("sts partial ack", 8'h58, 32'h03020000);
    check("masked request", irq_request, 1'b0);
    @(posedge clock_in);
    source_mask <= 32'h01000000;
    cycles(3);
    check("unmasked request", irq_request, 1'b1);
    @(posedge clock_in);
    pe_output   <= 1'b1;
    wr(8'h58, 32'hFFFFFFFF);
    rd("sts full ack", 8'h58, 32'h00000000);
    @(posedge clock_in);
    source_mask <= 32'h00020000;

    // Holdoff of three units, push-pull active high
    wr(8'h54, 32'h03000111);
    @(posedge clock_in);
    other_req <= 1'b1;
    cycles(4);
    other_req <= 1'b0;
    cycles(3);
    other_req <= 1'b1;
    measure("holdoff three", 3 * TDIV - 4, 3 * TDIV + 6);
    @(posedge clock_in);
    other_req <= 1'b0;
    cycles(3);
    rd("active set", 8'h54, 32'h03002111);
    @(posedge clock_in);
    power_event <= 1'b1;
    @(posedge clock_in);
    power_event <= 1'b0;
    measure("power bypass", 0, 4);
    wr(8'h58, 32'h00020000);
    cycles(40);
    rd("active clear", 8'h54, 32'h03000111);
    wr(8'h54, 32'h03004111);
    rd("restart", 8'h54, 32'h03002111);
    @(posedge clock_in);
    other_req <= 1'b1;
    cycles(2);
    check("withheld", irq_level, 1'b0);
    wr(8'h54, 32'h00000111);
    measure("zero interval", 0, 4);
    rd("zero cfg", 8'h54, 32'h00001111);
    wr(8'h54, 32'h01000111);
    @(posedge clock_in);
    other_req <= 1'b0;
    cycles(3);
    other_req <= 1'b1;
    measure("new interval", TDIV - 4, TDIV + 6);

    // Mid-run reset must bring every output back to its idle value
    @(posedge clock_in);
    rst_in    <= 1'b1;
    other_req <= 1'b0;
    cycles(2);
    rst_in <= 1'b0;
    cycles(1);
    check("mid reset level", irq_level, 1'b1);
    check("mid reset request", irq_request, 1'b0);
    rd("mid reset cfg", 8'h54, 32'h00000000);
    end_sim();
  end
endmodule : test_host_irq_output_control
